/* File: common/pad_cfg_pkg.sv */
// Package with register offsets, reset values and field codes for the pad speed and pull block.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package pad_cfg_pkg;
	localparam int          PIN_COUNT       = 16;
	localparam int          FIELD_W         = 2;
	localparam logic [7:0]  SPEED_OFFSET    = 8'h08;
	localparam logic [7:0]  PULL_OFFSET     = 8'h0C;
	localparam logic [31:0] SPEED_RST_PORTA = 32'h0C00_0000;
	localparam logic [31:0] PULL_RST_PORTA  = 32'h2400_0000;
	localparam logic [31:0] RST_OTHER       = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
	localparam logic [1:0]  SPEED_10M_CODE  = 2'h1;
	localparam logic [1:0]  SPEED_50M_CODE  = 2'h3;
	localparam logic [1:0]  PULL_UP_CODE    = 2'h1;
	localparam logic [1:0]  PULL_DOWN_CODE  = 2'h2;

	typedef struct packed {
		logic [PIN_COUNT-1:0] slow_2m;
		logic [PIN_COUNT-1:0] mid_10m;
		logic [PIN_COUNT-1:0] fast_50m;
	} speed_ctl_t;

	typedef struct packed {
		logic [PIN_COUNT-1:0] pull_up;
		logic [PIN_COUNT-1:0] pull_down;
	} pull_ctl_t;
endpackage : pad_cfg_pkg

/* File: design/pad_field_decode.sv */
// Decoder of one pin's speed field and pull field into one-hot speed controls and at most one pull control.
// Assumes register fields from the same clock domain; purely combinational.
`timescale 1ns/100ps
module pad_field_decode (
	input  wire logic [1:0] pin_speed_field_i,
	input  wire logic [1:0] pin_pull_field_i,
	output logic            slow_2m_o,
	output logic            mid_10m_o,
	output logic            fast_50m_o,
	output logic            pull_up_o,
	output logic            pull_down_o
);
	always_comb begin
		slow_2m_o   = ~pin_speed_field_i[0];
		mid_10m_o   = (pin_speed_field_i == pad_cfg_pkg::SPEED_10M_CODE);
		fast_50m_o  = (pin_speed_field_i == pad_cfg_pkg::SPEED_50M_CODE);
		pull_up_o   = (pin_pull_field_i == pad_cfg_pkg::PULL_UP_CODE);
		pull_down_o = (pin_pull_field_i == pad_cfg_pkg::PULL_DOWN_CODE);
	end
endmodule : pad_field_decode

/* File: design/pad_speed_pull_regs.sv */
// Speed and pull configuration registers of one I/O port, a classic Wishbone slave.
// Assumes one clock, synchronous active-high reset, and a 32-bit bus master.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
// What this block does
// - Speed register at 0x08, pin n in bits 2n+1 down to 2n.
// - Speed register resets to 0C000000 on port A, zero elsewhere.
// - Speed code x0 gives 2M, 01 gives 10M, 11 gives 50M.
// - Pull register at 0x0C, pin n in bits 2n+1 down to 2n.
// - Pull register resets to 24000000 on port A, zero elsewhere.
// - Pull code 00 floats, 01 pulls up, 10 pulls down, 11 reserved.
// - Fields change only by software write or by reset.
module pad_speed_pull_regs #(
	parameter bit IS_PORT_A = 1'b0
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	output pad_cfg_pkg::speed_ctl_t           speed_ctl_o,
	output pad_cfg_pkg::pull_ctl_t            pull_ctl_o
);
	// Bus word layout: four byte lanes of eight bits each.
	localparam int N      = pad_cfg_pkg::PIN_COUNT;
	localparam int W      = pad_cfg_pkg::FIELD_W;
	localparam int BYTES  = 4;
	localparam int BYTE_W = 8;

	// Limitations a user should know:
	// - only the two field words live here; every other offset answers with ack
	//   and reads zero, and a write to it is dropped without an error;
	// - the port's reset values are fixed at elaboration by IS_PORT_A;
	// - there is no write lock, so any write with a byte enable set changes
	//   the fields of every pin inside that byte.

	// Every pin's field must sit inside the one bus word that software reads, so
	// a pin count or field width that does not fill it exactly is refused here.
	if (N * W != BYTES * BYTE_W) begin : g_bad_fill
		$error("pin count and field width must fill one 32-bit word");
	end

	// The per-pin decoder takes exactly two bits of each field word.
	if (W != 2) begin : g_bad_width
		$error("the pin decoder serves two-bit fields only");
	end

	// Two registers at one offset would both answer the same access.
	if (pad_cfg_pkg::SPEED_OFFSET == pad_cfg_pkg::PULL_OFFSET) begin : g_bad_map
		$error("speed and pull registers need distinct offsets");
	end

	// Register group: the two software field words.
	logic [31:0]             speed_q;
	logic [31:0]             speed_d;
	logic [31:0]             pull_q;
	logic [31:0]             pull_d;

	// Bus group: the registered answer to the master.
	logic [31:0]             dat_q;
	logic [31:0]             dat_d;
	logic                    ack_q;
	logic                    ack_d;

	// Control group: the decoded pad controls.
	pad_cfg_pkg::speed_ctl_t speed_ctl_q;
	pad_cfg_pkg::speed_ctl_t speed_ctl_d;
	pad_cfg_pkg::pull_ctl_t  pull_ctl_q;
	pad_cfg_pkg::pull_ctl_t  pull_ctl_d;

	// Request decode, shared by the register and bus groups.
	logic                    req;
	logic                    wr_req;
	logic                    hit_speed;
	logic                    hit_pull;

	// Per-pin decoder results, one bit per pin.
	logic [N-1:0]            slow_w;
	logic [N-1:0]            mid_w;
	logic [N-1:0]            fast_w;
	logic [N-1:0]            up_w;
	logic [N-1:0]            down_w;

	// Merges write data into a register under the byte enables.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [BYTES-1:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < BYTES; b++) begin
			if (sel[b]) begin
				r[b*BYTE_W +: BYTE_W] = new_v[b*BYTE_W +: BYTE_W];
			end
		end
		return r;
	endfunction : merge_bytes

	// Tells whether a bus address selects the register at the given offset.
	function automatic logic addr_hits(input logic [7:0] adr, input logic [7:0] offset);
		return adr == offset;
	endfunction : addr_hits

	// Picks the value a register takes on reset, by port.
	function automatic logic [31:0] reset_word(input logic [31:0] porta_v);
		return IS_PORT_A ? porta_v : pad_cfg_pkg::RST_OTHER;
	endfunction : reset_word

	// Bus timing, as a master sees it:
	// - the edge that sees cyc and stb high with no answer out takes the request;
	// - a write lands in its register at that same edge;
	// - ack and read data stand for the one cycle after that edge;
	// - ack then falls even if the master still holds its strobe;
	// - the pad controls show a written value one cycle after the register does.
	// Byte enables steer writes only; reads always return the whole word.

	// A request is taken only while no answer is out, so a master that holds
	// its strobe through the acknowledge cycle is not served twice.
	always_comb begin
		req       = wb_cyc_i & wb_stb_i & ~ack_q;
		wr_req    = req & wb_we_i;
		hit_speed = addr_hits(wb_adr_i, pad_cfg_pkg::SPEED_OFFSET);
		hit_pull  = addr_hits(wb_adr_i, pad_cfg_pkg::PULL_OFFSET);
	end

	// Register group: only reset or a software write moves the fields.
	always_comb begin
		speed_d = speed_q;
		pull_d  = pull_q;
		if (rst_i) begin
			speed_d = reset_word(pad_cfg_pkg::SPEED_RST_PORTA);
			pull_d  = reset_word(pad_cfg_pkg::PULL_RST_PORTA);
		end else begin
			if (wr_req && hit_speed) begin
				speed_d = merge_bytes(speed_q, wb_dat_i, wb_sel_i);
			end
			if (wr_req && hit_pull) begin
				// The reserved pull code is kept as written; only the decoder
				// declines to turn it into a resistor.
				pull_d = merge_bytes(pull_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		speed_q <= speed_d;
		pull_q  <= pull_d;
	end

	// Bus group: the answer carries the register value from before any write
	// in the same access, and unmapped addresses read as zero.
	always_comb begin
		dat_d = dat_q;
		ack_d = req;
		if (rst_i) begin
			dat_d = pad_cfg_pkg::READ_ZERO;
			ack_d = 1'b0;
		end else if (req) begin
			if (hit_speed) begin
				dat_d = speed_q;
			end else if (hit_pull) begin
				dat_d = pull_q;
			end else begin
				dat_d = pad_cfg_pkg::READ_ZERO;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		dat_q <= dat_d;
		ack_q <= ack_d;
	end

	// Speed codes with a clear low bit all mean the slowest class, so the
	// decoder tests that bit alone for it; the pull decoder compares whole
	// codes, which leaves the reserved code with neither resistor on.
	for (genvar p = 0; p < N; p++) begin : g_pin
		pad_field_decode u_dec (
			.pin_speed_field_i (speed_q[p*W +: W]),
			.pin_pull_field_i  (pull_q[p*W +: W]),
			.slow_2m_o         (slow_w[p]),
			.mid_10m_o         (mid_w[p]),
			.fast_50m_o        (fast_w[p]),
			.pull_up_o         (up_w[p]),
			.pull_down_o       (down_w[p])
		);
	end

	// Control group: the pad controls are registered, so they follow a register
	// write by one cycle, and they are held off while reset is asserted.
	always_comb begin
		speed_ctl_d.slow_2m  = slow_w;
		speed_ctl_d.mid_10m  = mid_w;
		speed_ctl_d.fast_50m = fast_w;
		pull_ctl_d.pull_up   = up_w;
		pull_ctl_d.pull_down = down_w;
		if (rst_i) begin
			speed_ctl_d = '0;
			pull_ctl_d  = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		speed_ctl_q <= speed_ctl_d;
		pull_ctl_q  <= pull_ctl_d;
	end

	// Every output is a flip-flop seen through a plain wire.
	always_comb begin
		wb_dat_o    = dat_q;
		wb_ack_o    = ack_q;
		speed_ctl_o = speed_ctl_q;
		pull_ctl_o  = pull_ctl_q;
	end
endmodule : pad_speed_pull_regs

/* File: bench/pad_chk.sv */
// Checker of the pad speed and pull register block.
// Assumes a bind to every instance of that block.
`timescale 1ns/100ps
module pad_chk (
	input logic                    clk_i,
	input logic                    rst_i,
	input logic                    wb_cyc_i,
	input logic                    wb_stb_i,
	input logic                    wb_we_i,
	input logic [7:0]              wb_adr_i,
	input logic [31:0]             wb_dat_o,
	input logic                    wb_ack_o,
	input pad_cfg_pkg::speed_ctl_t speed_ctl_o,
	input pad_cfg_pkg::pull_ctl_t  pull_ctl_o
);
	logic [15:0] lo, hi;
	wire         req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_comb for (int i = 0; i < 16; i++) {hi[i], lo[i]} = wb_dat_o[2*i+:2];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_spd; req && !wb_we_i && wb_adr_i == 8'h08 ##1 wb_ack_o; endsequence
	sequence rd_pul; req && !wb_we_i && wb_adr_i == 8'h0C ##1 wb_ack_o; endsequence
	chk_ack_resp: assert property (req |=> wb_ack_o) else $error("no ack");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	chk_ack_idle: assert property (!wb_stb_i |=> !wb_ack_o) else $error("stray ack");
	chk_unmapped_zero: assert property (req && !(wb_adr_i inside {8'h08, 8'h0C})
		|=> wb_dat_o == 0) else $error("unmapped data");
	chk_speed_map: assert property (rd_spd |-> speed_ctl_o == {~lo, ~hi & lo, hi & lo})
		else $error("speed decode");
	chk_pull_map: assert property (rd_pul |-> pull_ctl_o == {~hi & lo, hi & ~lo})
		else $error("pull decode");
	chk_pull_excl: assert property ((pull_ctl_o[31:16] & pull_ctl_o[15:0]) == 0)
		else $error("both pulls");
	chk_ctl_hold: assert property (!$stable({speed_ctl_o, pull_ctl_o})
		|-> $past(wb_ack_o && wb_we_i) || $past(rst_i, 2)) else $error("control changed");
endmodule : pad_chk
bind pad_speed_pull_regs pad_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .speed_ctl_o, .pull_ctl_o);

/* File: bench/tb_top.sv */
// Bench of the pad speed and pull block: port A reset values, then random bus traffic.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/100ps
module tb_top;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0]  wb_adr_i = 0;
	logic [7:0]  adrs[4] = '{8'h08, 8'h0C, 8'h10, 8'h04};
	logic [3:0]  wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, m[2];
	int          n_fail = 0, comparisons = 0;
	always #12.5 clk_i = ~clk_i;
	pad_speed_pull_regs #(.IS_PORT_A(1'b1)) pad_speed_pull_regs_inst (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .speed_ctl_o(), .pull_ctl_o());
	task automatic cmp(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t: read %h, expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic k;
		k = a == pad_cfg_pkg::PULL_OFFSET;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (!k && a != pad_cfg_pkg::SPEED_OFFSET) begin
			if (!w) cmp(wb_dat_o, '0);
		end else if (!w) cmp(wb_dat_o, m[k]);
		else for (int i = 0; i < 32; i++)
			if (s[i/8]) m[k][i] = d[i];
	endtask : bus
	task automatic wrap_up;
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	initial begin
		#20us;
		n_fail++;
		wrap_up();
	end
	initial begin
		void'($urandom(44843));
		m[0] = pad_cfg_pkg::SPEED_RST_PORTA;
		m[1] = pad_cfg_pkg::PULL_RST_PORTA;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, pad_cfg_pkg::SPEED_OFFSET, '0, '0);
		bus(1'b0, pad_cfg_pkg::PULL_OFFSET, '0, '0);
		repeat (60) bus(1'($urandom), adrs[$urandom % 4], $urandom, 4'($urandom));
		wrap_up();
	end
endmodule : tb_top
